// ### rtl/ecl_loader.sv
// Power-on configuration loader with its Avalon-MM register slave.
// Assumes an EEPROM word reader on mclk answering each request with a
// one-cycle ack, and host pins that are asynchronous to mclk.
`timescale 1ns/1ps
// What this block does
// - Words 0-2 give the station address
// - Words 4-5 identification only when word3[1:0]=01
// - Host pin bits 4:0 only when word3[3:2]=01
// - Word 7 parts gated by word3 fields
// - Word 8 bits 4:0 only when word3[9:8]=01
// - Pin bit 0 selects chip-select polarity
// - Pin bit 1 selects read-strobe polarity
// - Pin bit 2 selects write-strobe polarity
// - Pin bit 3 selects interrupt output polarity
// - Pin bit 4 selects push-pull or open-collector interrupt
// - Wake bit 0 polarity, bit 1 level/pulse
// - Wake bit 2 enables magic packet wake
// - Wake bit 3 enables link change wake
// - Wake bit 8 selects alternate LED mode
// - Wake bits 14/15 crossover for ports 0/1
// - Word 16 fields gate word groups 17-52
// - Word 17 loads switch registers 52H/53H
// - Words 19-20 load port 0 control registers
// - Words 21-26 load ports 1,2,processor likewise
// - Words 27-30 load per-port VLAN tags
// - Word 31 loads priority map D0H/D1H
module ecl_loader
    import ecl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic ee_rd_req,
    output logic [ECL_AW-1:0] ee_word_addr,
    input wire logic ee_rd_ack,
    input wire logic [15:0] ee_rd_data,
    output logic loader_busy,
    output logic [47:0] station_addr,
    output logic [15:0] vendor_id,
    output logic [15:0] product_id,
    output logic [4:0] aux_cfg,
    output logic [7:0] sw_ctrl_52,
    output logic [7:0] sw_ctrl_53,
    output logic [3:0][7:0] port_ctrl_61,
    output logic [3:0][7:0] port_ctrl_66,
    output logic [3:0][7:0] port_ctrl_67,
    output logic [3:0][7:0] port_ctrl_6d,
    output logic [3:0][7:0] port_vtag_6e,
    output logic [3:0][7:0] port_vtag_6f,
    output logic [7:0] prio_map_d0,
    output logic [7:0] prio_map_d1,
    output logic ext_wr,
    output logic [ECL_AW-1:0] ext_word,
    output logic [15:0] ext_data,
    input wire logic host_cs_pin,
    input wire logic host_rd_pin,
    input wire logic host_wr_pin,
    output logic host_cs,
    output logic host_read_strobe,
    output logic host_write_strobe,
    input wire logic irq_req,
    output logic irq_o,
    output logic irq_oe,
    input wire logic magic_evt,
    input wire logic link_evt,
    input wire logic wake_clear,
    output logic wake_output,
    input wire logic [1:0] port_link_up,
    input wire logic [1:0] port_activity,
    input wire logic [1:0] port_full_duplex,
    input wire logic [1:0] port_speed100,
    output logic [1:0] port_link_led_n,
    output logic [1:0] port_duplex_led_n,
    output logic [1:0] port_speed_led_n,
    output logic [1:0] auto_crossover
);
    // ****************************************************************
    // Word selection
    // ****************************************************************
    function automatic logic ecl_en(input logic [15:0] w, input int pos);
        ecl_en = (w[pos+:2] == ECL_EN_CODE);
    endfunction : ecl_en

    // Whether image word k must be read, given enable words 3 and 16
    function automatic logic ecl_need(input logic [5:0] k, input logic [15:0] w3,
                                      input logic [15:0] w16);
        logic n;
        n = 1'b0;
        if (k <= ECL_W_ENA) n = 1'b1;
        else if (k == ECL_W_VID || k == ECL_W_PID) n = ecl_en(w3, ECL_F3_ID);
        else if (k == ECL_W_HPIN) n = ecl_en(w3, ECL_F3_HPIN);
        else if (k == ECL_W_WAKE) n = ecl_en(w3, ECL_F3_WAKE) | ecl_en(w3, ECL_F3_LED) |
                                      ecl_en(w3, ECL_F3_XOVR);
        else if (k == ECL_W_AUX) n = ecl_en(w3, ECL_F3_AUX);
        else if (k == ECL_W_GRP) n = 1'b1;
        else if (k == ECL_W_SW || k == ECL_W_SWRSV) n = ecl_en(w16, ECL_F16_SW);
        else if (k >= ECL_W_PCTL && k <= ECL_W_PCTL_END) n = ecl_en(w16, ECL_F16_PCTL);
        else if (k >= ECL_W_VTAG && k <= ECL_W_VTAG_END) n = ecl_en(w16, ECL_F16_VTAG);
        else if (k == ECL_W_PRIO) n = ecl_en(w16, ECL_F16_PRIO);
        else if (k >= ECL_W_EXT0 && k <= ECL_W_EXT0_END) n = ecl_en(w16, ECL_F16_EXT0);
        else if (k >= ECL_W_EXT1 && k <= ECL_W_EXT1_END) n = ecl_en(w16, ECL_F16_EXT1);
        else if (k >= ECL_W_EXT2 && k <= ECL_W_EXT2_END) n = ecl_en(w16, ECL_F16_EXT2);
        ecl_need = n;
    endfunction : ecl_need

    // First needed word above cur, or the end marker
    function automatic logic [5:0] ecl_next(input logic [5:0] cur, input logic [15:0] w3,
                                            input logic [15:0] w16);
        logic [5:0] r;
        r = ECL_W_END;
        for (int k = 62; k >= 0; k--) begin
            if (6'(k) > cur && ecl_need(6'(k), w3, w16)) r = 6'(k);
        end
        ecl_next = r;
    endfunction : ecl_next

    // ****************************************************************
    // Loader state machine
    // ****************************************************************
    ecl_state_t state_q;
    logic [5:0] cur_q;
    logic [15:0] data_q;
    logic [15:0] w3_q;
    logic [15:0] w16_q;
    logic [15:0] w3_eff;
    logic [15:0] w16_eff;
    logic [5:0] next_w;
    logic reload;
    logic apply;

    // Enables are used in the same cycle their own word is applied
    assign w3_eff = (cur_q == ECL_W_ENA) ? data_q : w3_q;
    assign w16_eff = (cur_q == ECL_W_GRP) ? data_q : w16_q;
    assign next_w = ecl_next(cur_q, w3_eff, w16_eff);
    assign apply = (state_q == ECL_ST_APPLY);
    assign ee_rd_req = (state_q == ECL_ST_FETCH);
    assign ee_word_addr = cur_q;
    assign loader_busy = (state_q != ECL_ST_IDLE);

    // Sequencing: reset lands in START so the image loads at power-on
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ECL_ST_START;
            cur_q <= ECL_W_MAC0;
            data_q <= 16'h0000;
            w3_q <= 16'h0000;
            w16_q <= 16'h0000;
        end else begin
            case (state_q)
                ECL_ST_START: begin
                    cur_q <= ECL_W_MAC0;
                    w3_q <= 16'h0000; // Unread enables count as off
                    w16_q <= 16'h0000;
                    state_q <= ECL_ST_FETCH;
                end
                ECL_ST_FETCH: begin
                    if (ee_rd_ack) begin
                        data_q <= ee_rd_data;
                        state_q <= ECL_ST_APPLY;
                    end
                end
                ECL_ST_APPLY: begin
                    w3_q <= w3_eff;
                    w16_q <= w16_eff;
                    cur_q <= next_w;
                    state_q <= (next_w == ECL_W_END) ? ECL_ST_IDLE : ECL_ST_FETCH;
                end
                ECL_ST_IDLE: begin
                    if (reload) state_q <= ECL_ST_START;
                end
                default: state_q <= ECL_ST_START;
            endcase
        end
    end

    // ****************************************************************
    // Identity and host-side configuration
    // ****************************************************************
    logic [4:0] hpin_q;
    logic [15:0] wake_q;

    // Gated words are only fetched when enabled, so apply needs no gate
    always_ff @(posedge mclk) begin
        if (rst) begin
            station_addr <= 48'h0;
            vendor_id <= ECL_RST_VID;
            product_id <= ECL_RST_PID;
            hpin_q <= ECL_RST_HPIN;
            aux_cfg <= 5'h00;
        end else if (apply) begin
            if (cur_q <= 6'h02) station_addr[cur_q[1:0]*16+:16] <= data_q;
            if (cur_q == ECL_W_VID) vendor_id <= data_q;
            if (cur_q == ECL_W_PID) product_id <= data_q;
            if (cur_q == ECL_W_HPIN) hpin_q <= data_q[4:0];
            if (cur_q == ECL_W_AUX) aux_cfg <= data_q[4:0];
        end
    end

    // Word 7 is split into three separately gated parts
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_q <= ECL_RST_WAKE;
        end else if (apply && cur_q == ECL_W_WAKE) begin
            if (ecl_en(w3_q, ECL_F3_WAKE)) wake_q[3:0] <= data_q[3:0];
            if (ecl_en(w3_q, ECL_F3_LED)) wake_q[13:8] <= data_q[13:8];
            if (ecl_en(w3_q, ECL_F3_XOVR)) wake_q[15:14] <= data_q[15:14];
        end
    end

    // ****************************************************************
    // Switch, per-port and priority registers
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            sw_ctrl_52 <= ECL_RST_BYTE;
            sw_ctrl_53 <= ECL_RST_BYTE;
            prio_map_d0 <= ECL_RST_BYTE;
            prio_map_d1 <= ECL_RST_BYTE;
        end else if (apply) begin
            if (cur_q == ECL_W_SW) begin
                sw_ctrl_52 <= data_q[7:0];
                sw_ctrl_53 <= data_q[15:8];
            end
            if (cur_q == ECL_W_PRIO) begin
                prio_map_d0 <= data_q[7:0];
                prio_map_d1 <= data_q[15:8];
            end
        end
    end

    // One copy per port: two control words and one tag word each
    for (genvar p = 0; p < 4; p++) begin : g_port
        localparam logic [5:0] CW = 6'(ECL_W_PCTL + 2 * p);
        localparam logic [5:0] TW = 6'(ECL_W_VTAG + p);
        always_ff @(posedge mclk) begin
            if (rst) begin
                port_ctrl_61[p] <= ECL_RST_BYTE;
                port_ctrl_66[p] <= ECL_RST_BYTE;
                port_ctrl_67[p] <= ECL_RST_BYTE;
                port_ctrl_6d[p] <= ECL_RST_BYTE;
                port_vtag_6e[p] <= ECL_RST_BYTE;
                port_vtag_6f[p] <= ECL_RST_BYTE;
            end else if (apply) begin
                if (cur_q == CW) begin
                    port_ctrl_61[p] <= data_q[7:0];
                    port_ctrl_66[p] <= data_q[15:8];
                end
                if (cur_q == CW + 6'h01) begin
                    port_ctrl_67[p] <= data_q[7:0];
                    port_ctrl_6d[p] <= data_q[15:8];
                end
                if (cur_q == TW) begin
                    port_vtag_6e[p] <= data_q[7:0];
                    port_vtag_6f[p] <= data_q[15:8];
                end
            end
        end
    end

    // Groups at words 32 and up are handed to the switch core as writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_wr <= 1'b0;
            ext_word <= 6'h00;
            ext_data <= 16'h0000;
        end else begin
            ext_wr <= apply && cur_q >= ECL_W_EXT0 && cur_q != ECL_W_END;
            if (apply) begin
                ext_word <= cur_q;
                ext_data <= data_q;
            end
        end
    end

    // ****************************************************************
    // Host pins, interrupt, wake and LEDs
    // ****************************************************************
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic wake_lvl_q;
    logic wake_evt;

    // Two-stage synchronisers for the asynchronous host strobes
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_q <= 3'h7;
            pin_s2_q <= 3'h7;
        end else begin
            pin_s1_q <= {host_wr_pin, host_rd_pin, host_cs_pin};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Strobes are presented active high whatever the pin polarity
    assign host_cs = (pin_s2_q[0] == hpin_q[0]);
    assign host_read_strobe = (pin_s2_q[1] == hpin_q[1]);
    assign host_write_strobe = (pin_s2_q[2] == hpin_q[2]);
    assign irq_o = irq_req ^ hpin_q[3];
    // Open collector only drives while asserted, else the pull-up holds
    assign irq_oe = !hpin_q[4] || irq_req;

    assign wake_evt = (magic_evt && wake_q[2]) || (link_evt && wake_q[3]);

    // Level mode holds until cleared; a new event beats the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_lvl_q <= 1'b0;
        end else if (wake_evt) begin
            wake_lvl_q <= 1'b1;
        end else if (wake_clear || wake_q[1]) begin
            wake_lvl_q <= 1'b0; // Pulse mode lasts one cycle
        end
    end

    assign wake_output = wake_lvl_q ^ wake_q[0];
    assign auto_crossover = {wake_q[15], wake_q[14]};
    // Alternate mode: link shows activity, duplex 100M, speed 10M
    assign port_link_led_n = wake_q[8] ? ~port_activity : ~port_link_up;
    assign port_duplex_led_n = wake_q[8] ? ~port_speed100 : ~port_full_duplex;
    assign port_speed_led_n = wake_q[8] ? port_speed100 : ~port_speed100;

    // ****************************************************************
    // Avalon-MM register slave
    // ****************************************************************
    logic rvalid_q;
    logic wr_take;
    logic rd_take;
    logic [31:0] rd_mux;

    // Bus is held off while loading, so no access can race the image
    assign avs_waitrequest = loader_busy || (avs_read && !rvalid_q);
    assign wr_take = avs_write && !loader_busy;
    assign rd_take = avs_read && !loader_busy && !rvalid_q;
    assign reload = wr_take && avs_address == ECL_R_CTRL && avs_byteenable[0] &&
                    avs_writedata[0];

    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            ECL_R_STAT: rd_mux = {31'h0, loader_busy};
            ECL_R_MACLO: rd_mux = station_addr[31:0];
            ECL_R_MACHI: rd_mux = {16'h0, station_addr[47:32]};
            ECL_R_ID: rd_mux = {product_id, vendor_id};
            ECL_R_CFG: rd_mux = {wake_q, 6'h0, aux_cfg, hpin_q};
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data registered; answered one cycle after the request
    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            rvalid_q <= rd_take;
            if (rd_take) avs_readdata <= rd_mux;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_bus_held_busy: assert property (@(posedge mclk) disable iff (rst)
        loader_busy && (avs_read || avs_write) |-> avs_waitrequest)
        else $error("bus access not held off while loading");
    chk_mac_word_load: assert property (@(posedge mclk) disable iff (rst)
        apply && cur_q == 6'h01 |=> station_addr[31:16] == $past(data_q))
        else $error("station address word not loaded");
    chk_id_fetch_gate: assert property (@(posedge mclk) disable iff (rst)
        ee_rd_req && (cur_q == ECL_W_VID) |-> ecl_en(w3_q, ECL_F3_ID))
        else $error("identification word read while disabled");
    chk_hpin_fetch_gate: assert property (@(posedge mclk) disable iff (rst)
        ee_rd_req && (cur_q == ECL_W_HPIN) |-> ecl_en(w3_q, ECL_F3_HPIN))
        else $error("host pin word read while disabled");
    chk_irq_open_drain: assert property (@(posedge mclk) disable iff (rst)
        hpin_q[4] && !irq_req |-> !irq_oe)
        else $error("open collector interrupt driven while idle");
    chk_wake_level_hold: assert property (@(posedge mclk) disable iff (rst)
        magic_evt && wake_q[2] && !wake_q[1] ##1 (!wake_clear)[*2]
        |-> wake_output != wake_q[0])
        else $error("level wake not held");
    chk_port_grp_gate: assert property (@(posedge mclk) disable iff (rst)
        ee_rd_req && cur_q >= ECL_W_PCTL && cur_q <= ECL_W_PCTL_END
        |-> ecl_en(w16_q, ECL_F16_PCTL))
        else $error("port control word read while disabled");
    chk_switch_load: assert property (@(posedge mclk) disable iff (rst)
        apply && cur_q == ECL_W_SW |=> sw_ctrl_53 == $past(data_q[15:8]))
        else $error("switch control high byte not loaded");
    chk_prio_load: assert property (@(posedge mclk) disable iff (rst)
        apply && cur_q == ECL_W_PRIO |=> prio_map_d0 == $past(data_q[7:0]))
        else $error("priority map low byte not loaded");
    chk_load_ends: assert property (@(posedge mclk) disable iff (rst)
        apply && next_w == ECL_W_END |=> !loader_busy)
        else $error("loader not idle after last word");
endmodule : ecl_loader

// ### rtl/ecl_pkg.sv
// Constants for the power-on configuration loader: image word map,
// enable codes, field positions, reset values and register offsets.
// Assumes a 16-bit word image of at most 64 words.
package ecl_pkg;
    // ****************************************************************
    // Image word map
    // ****************************************************************
    localparam int ECL_AW = 6;
    localparam logic [5:0] ECL_W_MAC0 = 6'h00;
    localparam logic [5:0] ECL_W_ENA = 6'h03;
    localparam logic [5:0] ECL_W_VID = 6'h04;
    localparam logic [5:0] ECL_W_PID = 6'h05;
    localparam logic [5:0] ECL_W_HPIN = 6'h06;
    localparam logic [5:0] ECL_W_WAKE = 6'h07;
    localparam logic [5:0] ECL_W_AUX = 6'h08;
    localparam logic [5:0] ECL_W_GRP = 6'h10;
    localparam logic [5:0] ECL_W_SW = 6'h11;
    localparam logic [5:0] ECL_W_SWRSV = 6'h12;
    localparam logic [5:0] ECL_W_PCTL = 6'h13;
    localparam logic [5:0] ECL_W_PCTL_END = 6'h1A;
    localparam logic [5:0] ECL_W_VTAG = 6'h1B;
    localparam logic [5:0] ECL_W_VTAG_END = 6'h1E;
    localparam logic [5:0] ECL_W_PRIO = 6'h1F;
    localparam logic [5:0] ECL_W_EXT0 = 6'h20;
    localparam logic [5:0] ECL_W_EXT0_END = 6'h27;
    localparam logic [5:0] ECL_W_EXT1 = 6'h28;
    localparam logic [5:0] ECL_W_EXT1_END = 6'h2F;
    localparam logic [5:0] ECL_W_EXT2 = 6'h31;
    localparam logic [5:0] ECL_W_EXT2_END = 6'h34;
    localparam logic [5:0] ECL_W_END = 6'h3F;
    localparam logic [1:0] ECL_EN_CODE = 2'h1;
    // ****************************************************************
    // Field positions inside word 3 and word 16 (low bit of each pair)
    // ****************************************************************
    localparam int ECL_F3_ID = 0;
    localparam int ECL_F3_HPIN = 2;
    localparam int ECL_F3_WAKE = 6;
    localparam int ECL_F3_AUX = 8;
    localparam int ECL_F3_LED = 10;
    localparam int ECL_F3_XOVR = 14;
    localparam int ECL_F16_SW = 0;
    localparam int ECL_F16_PCTL = 2;
    localparam int ECL_F16_VTAG = 4;
    localparam int ECL_F16_PRIO = 6;
    localparam int ECL_F16_EXT0 = 8;
    localparam int ECL_F16_EXT1 = 10;
    localparam int ECL_F16_EXT2 = 12;
    // ****************************************************************
    // Reset values (identification values are arbitrary)
    // ****************************************************************
    localparam logic [15:0] ECL_RST_VID = 16'h1234;
    localparam logic [15:0] ECL_RST_PID = 16'h5678;
    localparam logic [4:0] ECL_RST_HPIN = 5'h00;
    localparam logic [15:0] ECL_RST_WAKE = 16'hC000;
    localparam logic [7:0] ECL_RST_BYTE = 8'h00;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ECL_R_CTRL = 8'h00;
    localparam logic [7:0] ECL_R_STAT = 8'h04;
    localparam logic [7:0] ECL_R_MACLO = 8'h08;
    localparam logic [7:0] ECL_R_MACHI = 8'h0C;
    localparam logic [7:0] ECL_R_ID = 8'h10;
    localparam logic [7:0] ECL_R_CFG = 8'h14;
    typedef enum logic [2:0] {ECL_ST_START, ECL_ST_FETCH, ECL_ST_APPLY, ECL_ST_IDLE} ecl_state_t;
endpackage : ecl_pkg

// ### dv/ecl_eeprom_model.sv
// Behavioural serial EEPROM word reader holding the configuration image.
// Assumes the bench fills img while no fetch is in flight.
`timescale 1ns/1ps
module ecl_eeprom_model
    import ecl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow,
    input wire logic ee_rd_req,
    input wire logic [ECL_AW-1:0] ee_word_addr,
    output logic ee_rd_ack,
    output logic [15:0] ee_rd_data
);
    logic [15:0] img [0:63];
    logic [1:0] wait_q;
    // Slow mode waits three cycles; data is scrambled outside the ack cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            ee_rd_ack <= 1'b0;
            ee_rd_data <= 16'h0000;
            wait_q <= 2'h0;
        end else if (ee_rd_req && !ee_rd_ack && wait_q == (slow ? 2'h3 : 2'h0)) begin
            ee_rd_ack <= 1'b1;
            ee_rd_data <= img[ee_word_addr];
            wait_q <= 2'h0;
        end else begin
            ee_rd_ack <= 1'b0;
            ee_rd_data <= ~ee_rd_data;
            wait_q <= (ee_rd_req && !ee_rd_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule : ecl_eeprom_model

// ### dv/ecl_tb.sv
// Self-checking bench for the configuration loader and its register slave.
// Assumes the EEPROM model in ecl_eeprom_model and a 250 MHz clock.
`timescale 1ns/1ps
module testbench
    import ecl_pkg::*;
;
    logic mclk, rst, avs_read, avs_write, avs_waitrequest, ee_rd_req, ee_rd_ack, loader_busy;
    logic slow, host_cs_pin, host_rd_pin, host_wr_pin, host_cs, host_read_strobe;
    logic host_write_strobe, irq_req, irq_o, irq_oe, magic_evt, link_evt, wake_clear, wake_output;
    logic [7:0] avs_address, sw_ctrl_52, sw_ctrl_53, prio_map_d0, prio_map_d1, leds;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic [ECL_AW-1:0] ee_word_addr;
    logic [15:0] ee_rd_data, vendor_id, product_id;
    logic [47:0] station_addr;
    logic [4:0] aux_cfg;
    logic [3:0][7:0] port_ctrl_61, port_ctrl_66, port_ctrl_67, port_ctrl_6d, port_vtag_6e;
    logic [3:0][7:0] port_vtag_6f;
    logic [1:0] port_link_up, port_activity, port_full_duplex, port_speed100, auto_crossover;
    logic [1:0] port_link_led_n, port_duplex_led_n, port_speed_led_n;
    int mismatches, n_checks, nack, cyc;
    assign {port_link_up, port_activity, port_full_duplex, port_speed100} = leds;
    ecl_loader dut_u (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .ee_rd_req, .ee_word_addr, .ee_rd_ack,
        .ee_rd_data, .loader_busy, .station_addr, .vendor_id, .product_id, .aux_cfg, .sw_ctrl_52,
        .sw_ctrl_53, .port_ctrl_61, .port_ctrl_66, .port_ctrl_67, .port_ctrl_6d, .port_vtag_6e,
        .port_vtag_6f, .prio_map_d0, .prio_map_d1, .ext_wr(), .ext_word(), .ext_data(),
        .host_cs_pin, .host_rd_pin, .host_wr_pin, .host_cs, .host_read_strobe, .host_write_strobe,
        .irq_req, .irq_o, .irq_oe, .magic_evt, .link_evt, .wake_clear, .wake_output, .port_link_up,
        .port_activity, .port_full_duplex, .port_speed100, .port_link_led_n, .port_duplex_led_n,
        .port_speed_led_n, .auto_crossover);
    ecl_eeprom_model mem_u (.mclk, .rst, .slow, .ee_rd_req, .ee_word_addr, .ee_rd_ack,
        .ee_rd_data);
    // ********
    // Helpers
    // ********
    function automatic logic [15:0] w(input int i);
        return {8'h5A ^ 8'(i), 8'(i)};
    endfunction : w
    task cmp(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task image(input logic [15:0] ena3, input logic [15:0] ena16);
        for (int i = 0; i < 64; i++) mem_u.img[i] = w(i);
        mem_u.img[3] = ena3; // Reserved fields left zero
        mem_u.img[6] = 16'h001F;
        mem_u.img[7] = 16'h010F; // Reserved bits left zero
        mem_u.img[16] = ena16; // Top field left zero
        mem_u.img[18] = 16'h0000;
    endtask : image
    // Holds the request until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    // ********
    // Scenarios
    // ********
    task t_defaults;
        bus(1'b0, ECL_R_STAT, 32'h0);
        cmp(q, 0);
        cmp(nack, 5);
        cmp(station_addr, {w(2), w(1), w(0)});
        cmp({vendor_id, product_id}, {ECL_RST_VID, ECL_RST_PID});
        cmp({aux_cfg, sw_ctrl_53, port_ctrl_6d, port_vtag_6f, prio_map_d1}, 0);
        cmp({host_cs, host_read_strobe, host_write_strobe}, 3'b000);
        cmp({irq_o, irq_oe}, 2'b01);
        magic_evt <= 1'b1;
        link_evt <= 1'b1;
        @(posedge mclk);
        magic_evt <= 1'b0;
        link_evt <= 1'b0;
        repeat (3) @(negedge mclk);
        cmp(wake_output, 0);
        cmp({port_link_led_n, port_duplex_led_n, port_speed_led_n}, 6'h06);
        cmp(auto_crossover, 2'h3);
        bus(1'b0, ECL_R_CFG, 32'h0);
        cmp(q, 32'hC0000000);
        $display("test defaults done");
    endtask : t_defaults
    task t_loaded;
        image(16'h4545, 16'h1555);
        slow <= 1'b1;
        leds <= 8'hD9;
        irq_req <= 1'b1;
        nack = 0;
        bus(1'b1, ECL_R_CTRL, 32'h1);
        bus(1'b0, ECL_R_STAT, 32'h0);
        cmp(q, 0);
        cmp(nack, 45);
        cmp(aux_cfg, 5'h08);
        cmp({sw_ctrl_53, sw_ctrl_52, prio_map_d1, prio_map_d0}, {w(17), w(31)});
        for (int p = 0; p < 4; p++) begin
            cmp({port_ctrl_66[p], port_ctrl_61[p]}, w(19 + 2 * p));
            cmp({port_ctrl_6d[p], port_ctrl_67[p]}, w(20 + 2 * p));
            cmp({port_vtag_6f[p], port_vtag_6e[p]}, w(27 + p));
        end
        cmp({host_cs, host_read_strobe, host_write_strobe, irq_o, irq_oe}, 5'h1D);
        irq_req <= 1'b0;
        repeat (2) @(negedge mclk);
        cmp({irq_o, irq_oe, wake_output}, 3'h5);
        cmp({port_link_led_n, port_duplex_led_n, port_speed_led_n, auto_crossover}, 8'hA4);
        // Pulse mode, active low: one low cycle after a magic event
        @(posedge mclk);
        magic_evt <= 1'b1;
        @(posedge mclk);
        magic_evt <= 1'b0;
        @(negedge mclk);
        cmp(wake_output, 0);
        @(negedge mclk);
        cmp(wake_output, 1);
        bus(1'b0, ECL_R_CFG, 32'h0);
        cmp(q, 32'h010F011F);
        bus(1'b0, ECL_R_ID, 32'h0);
        cmp(q, {w(5), w(4)});
        bus(1'b0, ECL_R_MACLO, 32'h0);
        cmp(q, {w(1), w(0)});
        bus(1'b0, 8'h20, 32'h0);
        cmp(q, 0);
        $display("test loaded done");
    endtask : t_loaded
    task t_level;
        mem_u.img[7] = 16'h0104; // Level mode, active high, magic wake only
        bus(1'b1, ECL_R_CTRL, 32'h1);
        bus(1'b0, ECL_R_STAT, 32'h0);
        cmp(q, 0);
        magic_evt <= 1'b1;
        @(posedge mclk);
        magic_evt <= 1'b0;
        repeat (3) @(negedge mclk);
        cmp(wake_output, 1);
        @(posedge mclk);
        wake_clear <= 1'b1;
        @(posedge mclk);
        wake_clear <= 1'b0;
        @(negedge mclk);
        cmp(wake_output, 0);
        $display("test level done");
    endtask : t_level
    // ********
    // Clock, monitors and main sequence
    // ********
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (ee_rd_ack === 1'b1 && ee_rd_req === 1'b1) nack++;
        if (cyc == 20000) begin
            mismatches++;
            results;
        end
    end
    initial begin
        {rst, host_cs_pin, host_rd_pin, host_wr_pin} = 4'hF;
        {avs_read, avs_write, slow, irq_req, magic_evt, link_evt, wake_clear} = 7'h00;
        {avs_address, avs_writedata, avs_byteenable, leds} = {8'h00, 32'h0, 4'hF, 8'hC9};
        {mismatches, n_checks, nack, cyc} = 0;
        image(16'h8A8A, 16'h2AAA);
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        cmp(loader_busy, 1);
        t_defaults;
        t_loaded;
        t_level;
        results;
    end
endmodule : testbench
